// >>> bench/serial_shift_latch_sink_driver_tb.sv
// serial_shift_latch_sink_driver_tb: self-checking bench for ssl_driver
// assumes: ssl_host drives the four pins; 40 MHz reference clock
`timescale 1ns/10ps
`default_nettype none
module serial_shift_latch_sink_driver_tb;
  import ssl_pkg::*;
  logic       ref_clk_i, rst_i, sd, sc, ls, gn, c_rise, c_fall;
  logic [7:0] sinks;
  int         err_count, n_compared;
  ssl_host host (.ref_clk_i(ref_clk_i), .serial_data_o(sd),
    .shift_clk_o(sc), .latch_strobe_o(ls), .out_gate_n_o(gn));
  ssl_driver DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_data_i(sd),
    .shift_clk_i(sc), .latch_strobe_i(ls), .out_gate_n_i(gn),
    .cascade_out_rise_o(c_rise), .cascade_out_fall_o(c_fall),
    .sink_lines_o(sinks));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic load_and_show();
    host.set_ctl(1'b0, 1'b1);
    host.send_byte(8'hA5);
    check({7'h00, c_rise}, 8'h01);
    check({7'h00, c_fall}, 8'h01);
    host.set_ctl(1'b1, 1'b1);
    check(sinks, 8'h00);
    host.set_ctl(1'b0, 1'b0);
    check(sinks, 8'hA5);
  endtask : load_and_show
  task automatic blank_keep();
    host.set_ctl(1'b0, 1'b1);
    check(sinks, 8'h00);
    host.set_ctl(1'b0, 1'b0);
    check(sinks, 8'hA5);
  endtask : blank_keep
  // strobe rises on 3C then follows 81: edge capture would show 3C
  task automatic hold_then_follow();
    host.send_byte(8'h3C);
    check(sinks, 8'hA5);
    check({7'h00, c_rise}, 8'h00);
    check({7'h00, c_fall}, 8'h00);
    host.set_ctl(1'b1, 1'b1);
    host.send_byte(8'h81);
    check(sinks, 8'h00);
    check({7'h00, c_rise}, 8'h01);
    host.set_ctl(1'b1, 1'b0);
    check(sinks, 8'h81);
    host.set_ctl(1'b0, 1'b0);
    check(sinks, 8'h81);
  endtask : hold_then_follow
  // extra shift of a 0: rise output moves first, fall output a phase later
  task automatic cascade_lag();
    host.clk_level(1'b1);
    check({7'h00, c_rise}, 8'h00);
    check({7'h00, c_fall}, 8'h01);
    check(sinks, 8'h81);
    host.clk_level(1'b0);
    check({7'h00, c_fall}, 8'h00);
  endtask : cascade_lag
  initial begin
    #50000;
    err_count++;
    conclude();
  end
  initial begin
    rst_i      = 1'b1;
    err_count  = 0;
    n_compared = 0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    host.wait_clk(4);
    check(sinks, 8'h00);
    load_and_show();
    blank_keep();
    hold_then_follow();
    cascade_lag();
    conclude();
  end
endmodule : serial_shift_latch_sink_driver_tb
`default_nettype wire

// >>> bench/ssl_host.sv
// ssl_host: host pin driver model for the sink driver
// assumes: tasks are called just after a ref_clk_i rising edge
`timescale 1ns/10ps
`default_nettype none
module ssl_host (
  input  wire logic ref_clk_i,
  output logic      serial_data_o,
  output logic      shift_clk_o,
  output logic      latch_strobe_o,
  output logic      out_gate_n_o
);
  initial begin
    serial_data_o  = 1'b0;
    shift_clk_o    = 1'b0;
    latch_strobe_o = 1'b0;
    out_gate_n_o   = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_clk
  // msb first: first bit lands in the top stage
  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      serial_data_o <= v[i];
      wait_clk(6);
      shift_clk_o <= 1'b1;
      wait_clk(6);
      shift_clk_o <= 1'b0;
      wait_clk(6);
      // hold spent: show the inverse, never a stale level
      serial_data_o <= ~v[i];
      wait_clk(1);
    end
  endtask : send_byte
  task automatic clk_level(input logic level);
    shift_clk_o <= level;
    wait_clk(6);
  endtask : clk_level
  task automatic set_ctl(input logic strobe, input logic gate_n);
    latch_strobe_o <= strobe;
    out_gate_n_o   <= gate_n;
    wait_clk(8);
  endtask : set_ctl
endmodule : ssl_host
`default_nettype wire

// >>> common/ssl_pkg.sv
// ssl_pkg: shared constants for the serial shift latch sink driver
// assumes: included before rtl files; no registers reachable by software
package ssl_pkg;
  localparam int unsigned SSL_STAGES   = 8;
  localparam int unsigned SSL_SYNC_LEN = 3;
  localparam logic        SSL_SINK_OFF = 1'b0;
  localparam logic [7:0]  SSL_RST_DATA = 8'h00;
  localparam logic [1:0]  SSL_PHASE_RISE = 2'b01;
  localparam logic [1:0]  SSL_PHASE_FALL = 2'b10;
  typedef enum logic [1:0] {
    SSL_CLK_LOW  = 2'b00,
    SSL_CLK_HIGH = 2'b01
  } ssl_clk_state_t;
endpackage : ssl_pkg

// >>> rtl/ssl_driver.sv
// ssl_driver: eight-stage shift register, transparent latch, gated sinks
// assumes: host pins are asynchronous and sampled on ref_clk_i (40 MHz)
//
// Contract
// R1 - while the strobe is high every shift stage is copied into its latch bit.
// R2 - the latch stays transparent and follows the shift stages all strobe-high.
// R3 - with the strobe tied high the host keeps the gate high during shifting.
// R4 - a high gate input forces every sink output off.
// R5 - the gate input never alters the stored latch contents.
// R6 - with the gate low each sink output follows its own latch bit.
// R7 - each shift clock rising edge advances the register, taking serial data.
// R8 - the primary cascade output shows the last stage, updated on clock rise.
// R9 - the secondary cascade output shows the last stage, updated on clock fall.
// R10 - eight sink outputs exist, one per latch bit and stage.
// R11 - stage 0 takes serial input, others their predecessor; strobe low holds.
`timescale 1ns/10ps
`default_nettype none
module ssl_driver
  import ssl_pkg::*;
#(
  parameter int unsigned STAGES = SSL_STAGES
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              serial_data_i,
  input  wire logic              shift_clk_i,
  input  wire logic              latch_strobe_i,
  input  wire logic              out_gate_n_i,
  output logic                   cascade_out_rise_o,
  output logic                   cascade_out_fall_o,
  output logic [STAGES-1:0]      sink_lines_o
);
  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic data_s;
  logic clk_s;
  logic strobe_s;
  logic gate_n_s;

  // every pin crosses in by the same path, so their
  // relative timing is kept
  ssl_pin_sync #(.RST_VAL(1'b0)) u_sync_data (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (serial_data_i),
    .level_o   (data_s)
  );
  ssl_pin_sync #(.RST_VAL(1'b0)) u_sync_clk (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (shift_clk_i),
    .level_o   (clk_s)
  );
  ssl_pin_sync #(.RST_VAL(1'b0)) u_sync_strobe (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (latch_strobe_i),
    .level_o   (strobe_s)
  );
  // gate resets high: outputs blanked until the host says otherwise
  ssl_pin_sync #(.RST_VAL(1'b1)) u_sync_gate (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     (out_gate_n_i),
    .level_o   (gate_n_s)
  );

  // --------------------------------------------------------------
  // shift clock edge tracking
  // --------------------------------------------------------------
  ssl_clk_state_t clk_state_ff;
  logic           clk_rise;
  logic           clk_fall;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clk_state_ff <= SSL_CLK_LOW;
    end else begin
      clk_state_ff <= clk_s ? SSL_CLK_HIGH : SSL_CLK_LOW;
    end
  end

  // an edge is one cycle wide; a pulse shorter than the
  // filter delay is lost, which limits the shift rate
  always_comb begin
    clk_rise = 1'b0;
    clk_fall = 1'b0;
    case (clk_state_ff)
      SSL_CLK_LOW:  clk_rise = clk_s;
      SSL_CLK_HIGH: clk_fall = !clk_s;
      default:      clk_rise = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // shift register and cascade outputs
  // --------------------------------------------------------------
  logic [STAGES-1:0] shift_ff;
  logic [STAGES-1:0] nxt_shift;

  // data sampled with the edge, like the setup window of the pin
  assign nxt_shift = {shift_ff[STAGES-2:0], data_s}; // R11

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_ff <= SSL_RST_DATA[STAGES-1:0];
    end else if (clk_rise) begin
      shift_ff <= nxt_shift; // R7
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cascade_out_rise_o <= 1'b0;
    end else if (clk_rise) begin
      cascade_out_rise_o <= nxt_shift[STAGES-1]; // R8
    end
  end

  // registered copy of the last stage; trails the rise
  // output by the high phase of the shift clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cascade_out_fall_o <= 1'b0;
    end else if (clk_fall) begin
      cascade_out_fall_o <= shift_ff[STAGES-1]; // R9
    end
  end

  // --------------------------------------------------------------
  // latch and sink gating
  // --------------------------------------------------------------
  logic [STAGES-1:0] latch_ff;
  logic [STAGES-1:0] nxt_latch;

  // the latch is a register sampled per cycle; strobe
  // pulses shorter than the filter delay are not seen
  // level-sensitive: follows the fresh shift value in the same cycle
  assign nxt_latch = clk_rise ? nxt_shift : shift_ff;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      latch_ff <= SSL_RST_DATA[STAGES-1:0];
    end else if (strobe_s) begin
      latch_ff <= nxt_latch; // R1 R2
    end
  end // strobe low holds R11; gate never touches it R5

  // sinks read nxt_latch under the strobe so the outputs
  // do not lag the latch by a cycle
  // one register per sink line R10
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sink_lines_o <= {STAGES{SSL_SINK_OFF}};
    end else if (gate_n_s) begin
      sink_lines_o <= {STAGES{SSL_SINK_OFF}}; // R4
    end else begin
      sink_lines_o <= strobe_s ? nxt_latch : latch_ff; // R6
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  AST_SHIFT_ADV: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_rise |=> shift_ff == {$past(shift_ff[STAGES-2:0]), $past(data_s)})
    else $error("shift did not advance on clock rise"); // R7
  AST_SHIFT_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !clk_rise |=> $stable(shift_ff))
    else $error("shift moved without clock rise"); // R11
  AST_LATCH_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    strobe_s ##1 strobe_s |-> latch_ff == shift_ff)
    else $error("latch not transparent"); // R1
  AST_LATCH_TRANSP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    strobe_s ##1 strobe_s && clk_rise |=>
    latch_ff == {$past(shift_ff[STAGES-2:0]), $past(data_s)})
    else $error("latch missed a later shift"); // R2
  AST_LATCH_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !strobe_s |=> $stable(latch_ff))
    else $error("latch changed with strobe low"); // R11
  AST_GATE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    gate_n_s |=> sink_lines_o == {STAGES{SSL_SINK_OFF}})
    else $error("sinks on while gated"); // R4
  AST_GATE_KEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !strobe_s && $changed(gate_n_s) |=> $stable(latch_ff))
    else $error("gate disturbed latch"); // R5
  AST_SINK_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !gate_n_s && !strobe_s ##1 !strobe_s |-> sink_lines_o == latch_ff)
    else $error("sinks differ from latch"); // R6
  AST_CASC_RISE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 cascade_out_rise_o == shift_ff[STAGES-1])
    else $error("rise cascade wrong"); // R8
  AST_CASC_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_fall |=> cascade_out_fall_o == shift_ff[STAGES-1])
    else $error("fall cascade wrong"); // R9

  // --------------------------------------------------------------
  // checks: tracking, capture, holds, unblanking and reset
  // --------------------------------------------------------------
  AST_SINK_TRACK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !gate_n_s && strobe_s |=> sink_lines_o == latch_ff)
    else $error("sinks lag transparent latch"); // R6
  AST_LATCH_CAPTURE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    strobe_s && !clk_rise |=> latch_ff == $past(shift_ff))
    else $error("latch did not copy shift stages"); // R1
  AST_GATE_UNBLANK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(gate_n_s) && !strobe_s |=> sink_lines_o == latch_ff)
    else $error("unblank lost latch contents"); // R5
  AST_BLANK_KEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(gate_n_s) && !strobe_s |=>
    $stable(latch_ff) && sink_lines_o == {STAGES{SSL_SINK_OFF}})
    else $error("blanking disturbed latch"); // R5
  AST_CASC_RISE_NEW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clk_rise |=> cascade_out_rise_o == $past(shift_ff[STAGES-2]))
    else $error("rise cascade not new last stage"); // R8
  AST_CASC_RISE_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !clk_rise |=> $stable(cascade_out_rise_o))
    else $error("rise cascade moved off a rise"); // R8
  AST_CASC_FALL_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !clk_fall |=> $stable(cascade_out_fall_o))
    else $error("fall cascade moved off a fall"); // R9
  AST_RST_BLANK: assert property (@(posedge ref_clk_i)
    rst_i |=> sink_lines_o == {STAGES{SSL_SINK_OFF}})
    else $error("sinks on during reset"); // R4
endmodule : ssl_driver
`default_nettype wire

// >>> rtl/ssl_pin_sync.sv
// ssl_pin_sync: three-stage pin synchroniser with agreement filter
// assumes: input is asynchronous to ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module ssl_pin_sync
  import ssl_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [SSL_SYNC_LEN-1:0] sync_ff;

  // first stage only feeds the second; change accepted when 2nd and 3rd agree
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_ff <= {SSL_SYNC_LEN{RST_VAL}};
    end else begin
      sync_ff <= {sync_ff[SSL_SYNC_LEN-2:0], pin_i};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      level_o <= RST_VAL;
    end else if (sync_ff[SSL_SYNC_LEN-2] == sync_ff[SSL_SYNC_LEN-1]) begin
      level_o <= sync_ff[SSL_SYNC_LEN-1];
    end
  end
endmodule : ssl_pin_sync
`default_nettype wire
